// [logic/rsp_char_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface rsp_char_if;
  logic        rxd;
  logic [15:0] div;
  logic [1:0]  fmt;
  logic        en;
  logic [7:0]  data;
  logic        valid;
  logic        par_err;
  logic        stop_err;
  logic        busy;
  modport rx   (input rxd, div, fmt, en, output data, valid, par_err, stop_err, busy);
  modport core (output rxd, div, fmt, en, input data, valid, par_err, stop_err, busy);
endinterface
`default_nettype wire

// [logic/rsp_pkg.sv]
`default_nettype none
package rsp_pkg;
  // core clock rate and character layout
  localparam int unsigned CLK_HZ    = 10_000_000;
  localparam int unsigned DATA_BITS = 8;
  localparam logic [2:0]  LAST_BIT  = 3'h7;
  // baud selection codes, the last one is the default rate
  localparam logic [2:0]  BAUD_1200    = 3'h0;
  localparam logic [2:0]  BAUD_2400    = 3'h1;
  localparam logic [2:0]  BAUD_4800    = 3'h2;
  localparam logic [2:0]  BAUD_9600    = 3'h3;
  localparam logic [2:0]  BAUD_19200   = 3'h4;
  localparam logic [2:0]  BAUD_38400   = 3'h5;
  localparam logic [2:0]  BAUD_DEFAULT = BAUD_38400;
  // character formats
  localparam logic [1:0]  FMT_NONE1   = 2'h0;
  localparam logic [1:0]  FMT_NONE2   = 2'h1;
  localparam logic [1:0]  FMT_ODD     = 2'h2;
  localparam logic [1:0]  FMT_EVEN    = 2'h3;
  localparam int unsigned FMT_PAR_BIT = 1;
  localparam logic [1:0]  FMT_DEFAULT = FMT_NONE1;
  // inter-frame silence: 3.5 chars of 11 bits, rounded up to whole bits
  localparam logic [5:0]  GAP_BITS = 6'h27;

  // bit period in core clock cycles for a baud selection code
  function automatic logic [15:0] baud_div(input logic [2:0] sel);
    int unsigned rate;
    case (sel)
      BAUD_1200:  rate = 1200;
      BAUD_2400:  rate = 2400;
      BAUD_4800:  rate = 4800;
      BAUD_9600:  rate = 9600;
      BAUD_19200: rate = 19200;
      default:    rate = 38400;
    endcase
    return 16'(CLK_HZ / rate);
  endfunction
endpackage
`default_nettype wire

// [logic/rsp_rx_char.sv]
`timescale 1ns/1ps
`default_nettype none
module rsp_rx_char (
  input  wire logic core_clk,
  input  wire logic sys_rst,
  rsp_char_if.rx    ch
);
  typedef enum logic [2:0] {R_IDLE, R_START, R_DATA, R_PAR, R_STOP} rsp_rx_st_t;
  typedef struct packed {
    rsp_rx_st_t  st;
    logic [15:0] cnt;
    logic [2:0]  bitn;
    logic [7:0]  sh;
    logic        par;
    logic [7:0]  data;
    logic        valid;
    logic        perr;
    logic        serr;
  } rsp_rx_s_t;
  localparam rsp_rx_s_t RX_RST = '0;
  rsp_rx_s_t q, d;

  // mid-bit sampling, lsb first; glitchy start bits fall back to idle
  always_comb
  begin
    d = q;
    d.valid = 1'b0;
    if (q.cnt != 16'h0000)
      d.cnt = q.cnt - 16'h0001;
    case (q.st)
      R_IDLE:
        if (ch.en && !ch.rxd)
        begin
          d.st  = R_START;
          d.cnt = ch.div >> 1;
        end
      R_START:
        if (q.cnt == 16'h0000)
        begin
          d.st   = ch.rxd ? R_IDLE : R_DATA;
          d.cnt  = ch.div - 16'h0001;
          d.bitn = 3'h0;
          d.par  = (ch.fmt == rsp_pkg::FMT_ODD); // odd sum must end at zero too
        end
      R_DATA:
        if (q.cnt == 16'h0000)
        begin
          d.sh   = {ch.rxd, q.sh[7:1]}; // [RULE_04]
          d.par  = q.par ^ ch.rxd;
          d.cnt  = ch.div - 16'h0001;
          d.bitn = q.bitn + 3'h1;
          if (q.bitn == rsp_pkg::LAST_BIT)
            d.st = ch.fmt[rsp_pkg::FMT_PAR_BIT] ? R_PAR : R_STOP; // [RULE_05]
        end
      R_PAR:
        if (q.cnt == 16'h0000)
        begin
          d.par = q.par ^ ch.rxd;
          d.cnt = ch.div - 16'h0001;
          d.st  = R_STOP;
        end
      R_STOP:
        if (q.cnt == 16'h0000)
        begin
          // only the first stop bit is checked; a second one reads as idle
          d.st    = R_IDLE;
          d.valid = 1'b1;
          d.data  = q.sh;
          d.perr  = ch.fmt[rsp_pkg::FMT_PAR_BIT] & q.par; // [RULE_09]
          d.serr  = !ch.rxd; // [RULE_09]
        end
      default:
        d.st = R_IDLE;
    endcase
    // receiver is deaf while our own driver owns the pair
    if (!ch.en)
      d.st = R_IDLE; // [RULE_01]
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      q <= RX_RST;
    else
      q <= d;
  end

  assign ch.data     = q.data;
  assign ch.valid    = q.valid;
  assign ch.par_err  = q.perr;
  assign ch.stop_err = q.serr;
  assign ch.busy     = (q.st != R_IDLE);
endmodule // rsp_rx_char
`default_nettype wire

// [logic/rsp_second_port.sv]
// Functional notes
// [RULE_01] One differential pair, half duplex: only one party drives at a time.
// [RULE_02] After reset the port runs at 38400 bit/s until reconfigured.
// [RULE_03] User configuration selects the line rate, replacing the default.
// [RULE_04] Character is start bit, eight data bits, optional parity, stop bits.
// [RULE_05] Formats: none/1 stop, none/2 stop, odd/1 stop, even/1 stop.
// [RULE_06] With the network module fitted, user must choose none with one stop.
// [RULE_07] Carries Modbus-RTU framing like the built-in serial port.
// [RULE_08] Runs concurrently and independently of the built-in serial port.
// [RULE_09] Bad parity or stop bit in a character marks the whole frame discarded.
`timescale 1ns/1ps
`default_nettype none
module rsp_second_port (
  input  wire logic       core_clk,
  input  wire logic       sys_rst,
  input  wire logic       rx_pin,
  output logic            txd,
  output logic            drive_en,
  input  wire logic [2:0] baud_sel,
  input  wire logic [1:0] fmt_sel,
  input  wire logic       cfg_load,
  output logic [15:0]     bit_div,
  output logic [1:0]      fmt_now,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_valid,
  output logic            tx_ready,
  output logic [7:0]      rx_data,
  output logic            rx_valid,
  output logic            rx_frame_end,
  output logic            rx_frame_bad
);
  typedef enum logic [2:0] {T_IDLE, T_START, T_DATA, T_PAR, T_STOP1, T_STOP2} rsp_tx_st_t;
  typedef struct packed {
    logic        s1;
    logic        s2;
    logic [15:0] div;
    logic [1:0]  fmt;
    rsp_tx_st_t  tst;
    logic [15:0] tcnt;
    logic [2:0]  tbit;
    logic [7:0]  tsh;
    logic        tpar;
    logic        txd;
    logic        de;
    logic        tx_ready;
    logic [15:0] gcnt;
    logic [5:0]  gbits;
    logic        in_frame;
    logic        bad;
    logic [7:0]  rdata;
    logic        rvalid;
    logic        fend;
    logic        fbad;
  } rsp_top_s_t;

  localparam rsp_top_s_t TOP_RST = '{
    s1: 1'b1, s2: 1'b1,
    div: rsp_pkg::baud_div(rsp_pkg::BAUD_DEFAULT),
    fmt: rsp_pkg::FMT_DEFAULT,
    tst: T_IDLE, tcnt: 16'h0000, tbit: 3'h0, tsh: 8'h00, tpar: 1'b0,
    txd: 1'b1, de: 1'b0, tx_ready: 1'b1,
    gcnt: 16'h0000, gbits: 6'h00, in_frame: 1'b0, bad: 1'b0,
    rdata: 8'h00, rvalid: 1'b0, fend: 1'b0, fbad: 1'b0};

  rsp_top_s_t q, d;
  rsp_char_if chr ();
  logic       tx_take;
  logic       cfg_take;

  // own receiver and timers, nothing shared with the built-in port
  rsp_rx_char u_rx ( // [RULE_08]
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .ch       (chr)
  );

  assign chr.rxd = q.s2;
  assign chr.div = q.div;
  assign chr.fmt = q.fmt;
  assign chr.en  = !q.de; // [RULE_01]

  // a start bit already on the pair wins over our own byte, so two drivers never collide
  assign tx_take  = q.tx_ready && tx_valid && !chr.busy && chr.rxd; // [RULE_01]
  // config only changes while tx and rx are idle; a start bit seen that same cycle counts its half bit at the old rate
  assign cfg_take = cfg_load && (q.tst == T_IDLE) && !chr.busy && !tx_take;

  always_comb
  begin
    d = q;
    d.s1 = rx_pin;
    d.s2 = q.s1;
    d.rvalid = 1'b0;
    d.fend = 1'b0;

    // configuration from the meter settings
    if (cfg_take)
    begin
      d.div = rsp_pkg::baud_div(baud_sel); // [RULE_03]
      d.fmt = fmt_sel; // [RULE_05]
    end

    // transmitter
    if (q.tcnt != 16'h0000)
      d.tcnt = q.tcnt - 16'h0001;
    case (q.tst)
      T_IDLE:
        if (tx_take)
        begin
          d.tst  = T_START;
          d.txd  = 1'b0; // [RULE_04]
          d.de   = 1'b1; // [RULE_01]
          d.tcnt = q.div - 16'h0001;
          d.tsh  = tx_data;
          d.tbit = 3'h0;
          d.tpar = (^tx_data) ^ (q.fmt == rsp_pkg::FMT_ODD);
        end
      T_START:
        if (q.tcnt == 16'h0000)
        begin
          d.tst  = T_DATA;
          d.txd  = q.tsh[0];
          d.tcnt = q.div - 16'h0001;
        end
      T_DATA:
        if (q.tcnt == 16'h0000)
        begin
          d.tcnt = q.div - 16'h0001;
          if (q.tbit == rsp_pkg::LAST_BIT)
          begin
            d.tst = q.fmt[rsp_pkg::FMT_PAR_BIT] ? T_PAR : T_STOP1; // [RULE_05]
            d.txd = q.fmt[rsp_pkg::FMT_PAR_BIT] ? q.tpar : 1'b1;
          end
          else
          begin
            d.tsh  = q.tsh >> 1;
            d.txd  = q.tsh[1];
            d.tbit = q.tbit + 3'h1;
          end
        end
      T_PAR:
        if (q.tcnt == 16'h0000)
        begin
          d.tst  = T_STOP1;
          d.txd  = 1'b1;
          d.tcnt = q.div - 16'h0001;
        end
      T_STOP1:
        if (q.tcnt == 16'h0000)
        begin
          d.tcnt = q.div - 16'h0001;
          if (q.fmt == rsp_pkg::FMT_NONE2)
            d.tst = T_STOP2; // [RULE_05]
          else
          begin
            d.tst = T_IDLE;
            d.de  = 1'b0; // [RULE_01]
          end
        end
      T_STOP2:
        if (q.tcnt == 16'h0000)
        begin
          d.tst = T_IDLE;
          d.de  = 1'b0;
        end
      default:
      begin
        d.tst = T_IDLE;
        d.txd = 1'b1;
        d.de  = 1'b0;
      end
    endcase
    // no new character while a remote one is arriving on the pair
    d.tx_ready = (d.tst == T_IDLE) && !chr.busy && !(q.tst == T_IDLE && tx_take); // [RULE_01]

    // receive stream and rtu frame delimiting by line silence
    if (chr.valid)
    begin
      d.rdata    = chr.data;
      d.rvalid   = 1'b1;
      d.in_frame = 1'b1;
      d.gcnt     = 16'h0000;
      d.gbits    = 6'h00;
      if (chr.par_err || chr.stop_err)
        d.bad = 1'b1; // [RULE_09]
    end
    else if (chr.busy || q.de || !q.in_frame)
    begin
      d.gcnt  = 16'h0000;
      d.gbits = 6'h00;
    end
    else if (q.gbits == rsp_pkg::GAP_BITS)
    begin
      d.fend     = 1'b1; // [RULE_07]
      d.fbad     = q.bad; // [RULE_09]
      d.in_frame = 1'b0;
      d.bad      = 1'b0;
      d.gbits    = 6'h00;
    end
    else if (q.gcnt == q.div - 16'h0001)
    begin
      d.gcnt  = 16'h0000;
      d.gbits = q.gbits + 6'h01;
    end
    else
      d.gcnt = q.gcnt + 16'h0001;
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      q <= TOP_RST; // [RULE_02]
    else
      q <= d;
  end

  assign txd          = q.txd;
  assign drive_en     = q.de;
  assign bit_div      = q.div;
  assign fmt_now      = q.fmt;
  assign tx_ready     = q.tx_ready;
  assign rx_data      = q.rdata;
  assign rx_valid     = q.rvalid;
  assign rx_frame_end = q.fend;
  assign rx_frame_bad = q.fbad;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  half_duplex_a: assert property (q.de |-> !chr.valid && !chr.busy) // [RULE_01]
    else $error("receiver active while driving");
  default_rate_a: assert property ($past(sys_rst) |-> q.div == rsp_pkg::baud_div(rsp_pkg::BAUD_DEFAULT)) // [RULE_02]
    else $error("default rate not set after reset");
  rate_load_a: assert property (cfg_take |=> q.div == rsp_pkg::baud_div($past(baud_sel))) // [RULE_03]
    else $error("selected rate not loaded");
  start_bit_a: assert property (tx_take |=> !q.txd && q.de ##1 (!q.txd && q.de)) // [RULE_04]
    else $error("start bit not driven");
  stop_level_a: assert property ((q.tst == T_STOP1 || q.tst == T_STOP2) |-> q.txd && q.de) // [RULE_04]
    else $error("stop bit not high");
  two_stop_a: assert property ((q.tst == T_STOP1 && q.tcnt == 16'h0000 && q.fmt == rsp_pkg::FMT_NONE2)
    |=> q.tst == T_STOP2 && q.de) // [RULE_05]
    else $error("second stop bit missing");
  bad_mark_a: assert property (chr.valid && (chr.par_err || chr.stop_err) |=> q.bad || q.fend) // [RULE_09]
    else $error("bad character not recorded");
  frame_end_a: assert property (q.in_frame && !chr.busy && !chr.valid && !q.de && q.gbits == rsp_pkg::GAP_BITS
    |=> rx_frame_end && rx_frame_bad == $past(q.bad)) // [RULE_07]
    else $error("frame end missing after silence");

  tx_parity_c: cover property (q.tst == T_PAR);
  rx_frame_c:  cover property (rx_frame_end && !rx_frame_bad);
  rx_bad_c:    cover property (rx_frame_end && rx_frame_bad);
  cfg_c:       cover property (cfg_take && fmt_sel == rsp_pkg::FMT_NONE2);
endmodule // rsp_second_port
`default_nettype wire

// [test/rsp_master_model.sv]
`timescale 1ns/1ps
`default_nettype none
module rsp_master_model (
  input  wire logic core_clk,
  input  wire logic txd,
  input  wire logic drive_en,
  output logic      line
);
  // failsafe bias keeps the idle pair high
  initial line = 1'h1;

  // hold the pair at v for n cycles, changed just after an edge
  task automatic hold(input logic v, input int n);
    @(posedge core_clk);
    #1 line = v;
    repeat (n - 1) @(posedge core_clk);
  endtask

  // one character; bp flips parity, bs breaks the first stop bit
  task automatic send(input logic [7:0] d, input logic [1:0] f, input int n, input logic bp, input logic bs);
    wait (drive_en === 1'h0);
    hold(1'h0, n);
    for (int i = 0; i < 8; i++)
      hold(d[i], n);
    if (f[1])
      hold(^d ^ ~f[0] ^ bp, n);
    hold(~bs, n);
    if (f == 2'h1)
      hold(1'h1, n);
    hold(1'h1, 1);
  endtask

  // sample eleven bit slots at mid-bit once the device grabs the pair
  task automatic take(input int n, output logic [10:0] b);
    @(posedge drive_en);
    for (int i = 0; i < 11; i++)
    begin
      repeat (i == 0 ? n / 2 : n) @(posedge core_clk);
      #1 b[i] = txd;
    end
  endtask
endmodule // rsp_master_model
`default_nettype wire

// [test/test_rs485_second_serial_port.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) \
  begin \
    cmp_count++; \
    if ((g) !== (e)) \
    begin \
      fails++; \
      $display("ERROR %s expected %0h seen %0h", nm, e, g); \
    end \
  end
module test_rs485_second_serial_port;
  localparam int DIV = 260;
  logic        core_clk, sys_rst, rx_pin, txd, drive_en, cfg_load;
  logic        tx_valid, tx_ready, rx_valid, rx_frame_end, rx_frame_bad, line;
  logic [2:0]  baud_sel;
  logic [1:0]  fmt_sel, fmt_now;
  logic [15:0] bit_div;
  logic [7:0]  tx_data, rx_data;
  logic [7:0]  got_q[$];
  logic        bad_q[$];
  int          fails, cmp_count;

  // device's own driver echoes onto its receiver while it owns the pair
  assign rx_pin = drive_en ? txd : line;

  rsp_second_port rsp_second_port_i (.core_clk(core_clk), .sys_rst(sys_rst), .rx_pin(rx_pin), .txd(txd),
    .drive_en(drive_en), .baud_sel(baud_sel), .fmt_sel(fmt_sel), .cfg_load(cfg_load), .bit_div(bit_div),
    .fmt_now(fmt_now), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data),
    .rx_valid(rx_valid), .rx_frame_end(rx_frame_end), .rx_frame_bad(rx_frame_bad));
  rsp_master_model rsp_master_model_i (.core_clk(core_clk), .txd(txd), .drive_en(drive_en), .line(line));

  // 10 MHz core clock
  initial
  begin
    core_clk = 1'h0;
    forever #50 core_clk = ~core_clk;
  end

  // collect received bytes and frame verdicts mid-cycle, clear of the launching edge
  always @(negedge core_clk)
  begin
    if (rx_valid === 1'h1)
      got_q.push_back(rx_data);
    if (rx_frame_end === 1'h1)
      bad_q.push_back(rx_frame_bad);
  end

  function automatic logic [15:0] exp_div(input logic [2:0] c);
    int r [6] = '{1200, 2400, 4800, 9600, 19200, 38400};
    return 16'(rsp_pkg::CLK_HZ / r[c > 5 ? 5 : c]);
  endfunction

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic cfg(input logic [2:0] c, input logic [1:0] f);
    baud_sel = c;
    fmt_sel = f;
    cfg_load = 1'h1;
    @(posedge core_clk);
    #1 cfg_load = 1'h0;
    @(posedge core_clk);
    #1;
    `CHK("bit_div", exp_div(c), bit_div)
    `CHK("fmt_now", f, fmt_now)
  endtask

  // one byte out, checked bit by bit on the wire
  task automatic tx_one(input logic [1:0] f);
    logic [7:0]  d;
    logic [10:0] b;
    d = 8'($urandom);
    tx_data = d;
    tx_valid = 1'h1;
    fork
      rsp_master_model_i.take(DIV, b);
      begin
        @(posedge core_clk);
        #1 tx_valid = 1'h0;
      end
    join
    `CHK("tx frame", {1'h1, f[1] ? ^d ^ ~f[0] : 1'h1, d, 1'h0}, b)
    // look one step after each edge so the registered outputs have settled
    for (int i = 0; i < 3 * DIV && tx_ready !== 1'h1; i++)
      @(posedge core_clk) #1;
    `CHK("tx_ready", 1'h1, tx_ready)
    `CHK("drive_en", 1'h0, drive_en)
  endtask

  // two characters back to back, then the silence that closes the frame
  task automatic rx_frame(input logic [1:0] f, input logic bp, input logic bs);
    logic [7:0] d [2];
    got_q = {};
    bad_q = {};
    for (int i = 0; i < 2; i++)
    begin
      d[i] = 8'($urandom);
      rsp_master_model_i.send(d[i], f, DIV, i == 1 && bp, i == 1 && bs);
    end
    for (int i = 0; i < 20000 && bad_q.size() == 0; i++)
      @(posedge core_clk);
    #1;
    `CHK("frame ends", 1, bad_q.size())
    if (bad_q.size() == 1)
      `CHK("frame_bad", bp | bs, bad_q[0])
    if (!(bp | bs) && got_q.size() == 2)
      for (int i = 0; i < 2; i++)
        `CHK("rx_data", d[i], got_q[i])
  endtask

  // watchdog: the run needs about 58k cycles, give up at 90k
  initial
  begin
    #9_000_000;
    fails++;
    stop_test();
  end

  // main sequence
  initial
  begin
    void'($urandom(32'hA8888E00));
    sys_rst = 1'h1;
    cfg_load = 1'h0;
    tx_valid = 1'h0;
    baud_sel = 3'h0;
    fmt_sel = 2'h0;
    tx_data = 8'h00;
    repeat (4) @(posedge core_clk);
    #1 sys_rst = 1'h0;
    `CHK("bit_div", 16'h0104, bit_div)
    `CHK("reset outs", 5'h03, {fmt_now, drive_en, txd, tx_ready})
    for (int c = 0; c < 8; c++)
      cfg(3'(c), 2'(c));
    for (int f = 0; f < 4; f++)
    begin
      cfg(3'h5, 2'(f));
      tx_one(2'(f));
    end
    cfg(3'h5, 2'h3);
    rx_frame(2'h3, 1'h0, 1'h0);
    cfg(3'h5, 2'h2);
    rx_frame(2'h2, 1'h1, 1'h0);
    // master side set up as a network module needs it: no parity, one stop bit
    cfg(3'h5, 2'h0);
    rx_frame(2'h0, 1'h0, 1'h1);
    stop_test();
  end
endmodule // test_rs485_second_serial_port
`default_nettype wire
